// ### rivm_vector_map.sv
// Reset and interrupt vector address generator for the core fetch unit
//
// Operation
// - Every system reset cause fetches vector 1, default word zero.
// - Requests 0x0002/0x0004, pin change 0x0006-0x000A, watchdog 0x000C.
// - Timer 2 compare A, compare B, overflow at 0x000E to 0x0012.
// - Timer 1 capture, compare A, compare B, overflow at 0x0014-0x001A.
// - Timer 0 compare A, compare B, overflow at 0x001C to 0x0020.
// - SPI done 0x0022; serial receive, empty, transmit 0x0024-0x0028.
// - Converter, nonvolatile, comparator, two-wire, store at 0x002A-0x0032.
// - Programmed boot fuse starts execution at the boot reset address.
// - Table select set adds the boot section start to each address.
// - Table starts at 0x002, or boot reset address plus 0x0002.
// - Fuse value 1 means word zero, value 0 means boot address.
// - Reset location and table location are chosen independently.
// - With 2 Kbyte boot area the programmed reset address is 0x1C00.
// - With 2 Kbyte boot area and table select, vectors span 0x1C02-0x1C32.
`timescale 1ns/10ps
module rivm_vector_map
   import rivm_pkg::*;
(
   // Clock and reset
   input  wire logic               i_clk,
   input  wire logic               i_rst_n,
   // Configuration
   input  wire logic               i_boot_reset_select_fuse,
   input  wire logic               i_vector_table_select_bit,
   input  wire logic [ADDR_W-1:0]  i_boot_reset_addr,
   // Reset causes: pin, power-on, brown-out, watchdog
   input  wire logic [3:0]         i_reset_cause,
   // Peripheral requests and core dispatch request
   input  wire logic [NUM_IRQ-1:0] i_irq_req,
   input  wire logic               i_dispatch_req,
   // Fetch address to the core
   output logic                    o_fetch_valid,
   output logic [ADDR_W-1:0]       o_fetch_addr,
   output logic [4:0]              o_vec_num,
   output logic                    o_is_reset
);

   // ---------------------------------------------------------------
   // Address functions
   // ---------------------------------------------------------------

   // Reset address from the fuse; never looks at the table select
   function automatic logic [ADDR_W-1:0] reset_addr_f
   (
      input logic              fuse,
      input logic [ADDR_W-1:0] boot
   );
      reset_addr_f = (fuse == FUSE_PROGRAMMED) ? boot
                                               : APP_RESET_ADDR;
   endfunction

   // Table base plus a two-word slot per source index
   function automatic logic [ADDR_W-1:0] vec_addr_f
   (
      input logic [IDX_W-1:0]  idx,
      input logic              sel,
      input logic [ADDR_W-1:0] boot
   );
      logic [ADDR_W-1:0] base;
      base = sel ? (boot + APP_TABLE_BASE) : APP_TABLE_BASE;
      vec_addr_f = base + {7'h00, idx, 1'b0};
   endfunction

   // ---------------------------------------------------------------
   // Request selection
   // ---------------------------------------------------------------
   logic             pick_any;
   logic [IDX_W-1:0] pick_idx;

   // Priority is the core's concern; lowest index is a fixed fallback
   rivm_req_pick u_pick
   (
      .i_req   (i_irq_req),
      .o_any   (pick_any),
      .o_index (pick_idx)
   );

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   rivm_state_t       state_r,       state_nxt;
   logic              fuse_r,        fuse_nxt;
   logic [ADDR_W-1:0] boot_r,        boot_nxt;
   logic              fetch_valid_r, fetch_valid_nxt;
   logic [ADDR_W-1:0] fetch_addr_r,  fetch_addr_nxt;
   logic [4:0]        vec_num_r,     vec_num_nxt;
   logic              is_reset_r,    is_reset_nxt;
   logic              any_cause;

   // Causes count only in RUN; one during the sequence is absorbed
   assign any_cause = |i_reset_cause;

   // Next values; a reset cause outranks a dispatch in the same cycle
   always_comb
   begin
      state_nxt       = state_r;
      fuse_nxt        = fuse_r;
      boot_nxt        = boot_r;
      fetch_valid_nxt = 1'b0;
      fetch_addr_nxt  = fetch_addr_r;
      vec_num_nxt     = vec_num_r;
      is_reset_nxt    = is_reset_r;
      unique case (state_r)
         RIVM_ST_CAPTURE:
         begin
            // Straps are caught after reset release, not under it
            fuse_nxt  = i_boot_reset_select_fuse;
            boot_nxt  = i_boot_reset_addr;
            state_nxt = RIVM_ST_ISSUE;
         end
         RIVM_ST_ISSUE:
         begin
            fetch_valid_nxt = 1'b1;
            fetch_addr_nxt  = reset_addr_f(fuse_r, boot_r);
            vec_num_nxt     = VEC_NUM_RESET;
            is_reset_nxt    = 1'b1;
            state_nxt       = RIVM_ST_RUN;
         end
         RIVM_ST_RUN:
         begin
            if (any_cause)
            begin
               state_nxt = RIVM_ST_CAPTURE;
            end
            else if (i_dispatch_req && pick_any)
            begin
               // Table select is live so software may move the table
               fetch_valid_nxt = 1'b1;
               fetch_addr_nxt  = vec_addr_f(pick_idx,
                                            i_vector_table_select_bit,
                                            boot_r);
               vec_num_nxt     = VEC_NUM_FIRST + pick_idx;
               is_reset_nxt    = 1'b0;
            end
         end
         default:
         begin
            state_nxt = RIVM_ST_CAPTURE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_r       <= RIVM_ST_CAPTURE;
         fuse_r        <= 1'b1;
         boot_r        <= BOOT_RESET_DFL;
         fetch_valid_r <= 1'b0;
         fetch_addr_r  <= APP_RESET_ADDR;
         vec_num_r     <= VEC_NUM_RESET;
         is_reset_r    <= 1'b1;
      end
      else
      begin
         state_r       <= state_nxt;
         fuse_r        <= fuse_nxt;
         boot_r        <= boot_nxt;
         fetch_valid_r <= fetch_valid_nxt;
         fetch_addr_r  <= fetch_addr_nxt;
         vec_num_r     <= vec_num_nxt;
         is_reset_r    <= is_reset_nxt;
      end
   end

   // Outputs straight from flops
   assign o_fetch_valid = fetch_valid_r;
   assign o_fetch_addr  = fetch_addr_r;
   assign o_vec_num     = vec_num_r;
   assign o_is_reset    = is_reset_r;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------

   // Any reset cause seen in RUN leads to the reset fetch three cycles later
   a_cause_to_reset: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (state_r == RIVM_ST_RUN && any_cause)
      |-> ##3 (fetch_valid_r && is_reset_r && vec_num_r == VEC_NUM_RESET))
      else $error("reset cause did not yield reset fetch");

   // Reset fetch address follows the captured fuse only
   a_reset_addr_sel: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (fetch_valid_r && is_reset_r)
      |-> (fetch_addr_r == ((fuse_r == 1'b0) ? boot_r : 13'h0000)))
      else $error("reset fetch address wrong for fuse");

   // Fuse value 1 always gives word zero on reset
   a_fuse_unprog: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (fetch_valid_r && is_reset_r && fuse_r)
      |-> (fetch_addr_r == 13'h0000))
      else $error("unprogrammed fuse not at word zero");

   // Programmed fuse with 2 Kbyte boot area resets at 0x1C00
   a_boot_reset_2k: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (fetch_valid_r && is_reset_r && !fuse_r && boot_r == 13'h1C00)
      |-> (fetch_addr_r == 13'h1C00))
      else $error("boot reset address not 0x1C00");

   // Application table: vector number n sits at word 2*(n-1)
   a_app_table_slot: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (fetch_valid_r && !is_reset_r && !$past(i_vector_table_select_bit))
      |-> (fetch_addr_r == {7'h00, vec_num_r - 5'h01, 1'b0}))
      else $error("vector not at its application table slot");

   // Dispatch answers next cycle with lowest pending source
   a_dispatch_addr: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (state_r == RIVM_ST_RUN && !any_cause && i_dispatch_req && pick_any)
      |=> (fetch_valid_r && !is_reset_r
           && vec_num_r == $past(pick_idx) + 5'h02
           && fetch_addr_r == ($past(i_vector_table_select_bit) ? boot_r
                                                                : 13'h0000)
                              + 13'h0002 + {7'h00, $past(pick_idx), 1'b0}))
      else $error("dispatch address or timing wrong");

   // Moved table: address is boot start plus default address
   a_moved_table: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (fetch_valid_r && !is_reset_r && $past(i_vector_table_select_bit))
      |-> (fetch_addr_r == boot_r + {7'h00, vec_num_r - 5'h01, 1'b0}))
      else $error("moved vector not offset by boot start");

   // 2 Kbyte boot area with moved table spans 0x1C02 to 0x1C32
   a_boot_span_2k: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (fetch_valid_r && !is_reset_r && boot_r == 13'h1C00
       && $past(i_vector_table_select_bit))
      |-> (fetch_addr_r >= 13'h1C02 && fetch_addr_r <= BOOT_LAST_VEC))
      else $error("moved vector outside boot span");

   // The strap is sampled only in the capture state
   a_boot_captured: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (state_r == RIVM_ST_CAPTURE)
      |=> (boot_r == $past(i_boot_reset_addr)
           && fuse_r == $past(i_boot_reset_select_fuse)))
      else $error("boot configuration not captured");

   // No dispatch without a pending request
   a_no_idle_fetch: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (state_r == RIVM_ST_RUN && !pick_any) |=> !fetch_valid_r)
      else $error("fetch issued with no pending request");

   // The chosen source is pending and nothing below it is
   a_lowest_pending: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (state_r == RIVM_ST_RUN && !any_cause && i_dispatch_req && pick_any)
      |=> ((($past(i_irq_req) >> (vec_num_r - 5'h02)) & 25'h0000001)
             != 25'h0000000
           && ($past(i_irq_req)
               & ((25'h0000001 << (vec_num_r - 5'h02)) - 25'h0000001))
              == 25'h0000000))
      else $error("dispatched source is not the lowest pending one");

   // Capture always hands over to the issue state on the next edge
   a_capture_issue: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (state_r == RIVM_ST_CAPTURE) |=> (state_r == RIVM_ST_ISSUE))
      else $error("capture state did not move on to issue");

   // Issue state always raises the reset vector fetch
   a_issue_fetch: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (state_r == RIVM_ST_ISSUE)
      |=> (fetch_valid_r && is_reset_r && vec_num_r == VEC_NUM_RESET
           && state_r == RIVM_ST_RUN))
      else $error("issue state gave no reset fetch");

   // A reset cause wins over a dispatch in the same cycle
   a_cause_first: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (state_r == RIVM_ST_RUN && any_cause)
      |=> (!fetch_valid_r && state_r == RIVM_ST_CAPTURE))
      else $error("dispatch answered despite a reset cause");

   // No interrupt vector leaves while a reset is under way
   a_no_early_vector: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (state_r != RIVM_ST_RUN) |=> !(fetch_valid_r && !is_reset_r))
      else $error("vector fetched during reset sequence");

   // The unused state code is never reached
   a_state_legal: assert property (
      @(posedge i_clk) disable iff (!i_rst_n)
      (state_r == RIVM_ST_CAPTURE || state_r == RIVM_ST_ISSUE
       || state_r == RIVM_ST_RUN))
      else $error("sequencer state code illegal");

endmodule

// ### rivm_pkg.sv
// Constants and types shared by the reset and interrupt vector map
package rivm_pkg;

   // ---------------------------------------------------------------
   // Address space
   // ---------------------------------------------------------------
   localparam int          ADDR_W         = 13;      // Word address width
   localparam int          NUM_IRQ        = 25;      // Interrupt sources
   localparam int          IDX_W          = 5;       // Source index width
   localparam logic [12:0] APP_RESET_ADDR = 13'h0000;
   localparam logic [12:0] APP_TABLE_BASE = 13'h0002;
   localparam logic [12:0] BOOT_RESET_DFL = 13'h1C00; // 2 Kbyte boot area
   localparam logic [12:0] BOOT_LAST_VEC  = 13'h1C32;
   localparam logic        FUSE_PROGRAMMED = 1'b0;   // 0 = programmed

   // ---------------------------------------------------------------
   // Vector numbers
   // ---------------------------------------------------------------
   localparam logic [4:0]  VEC_NUM_RESET  = 5'h01;
   localparam logic [4:0]  VEC_NUM_FIRST  = 5'h02;   // Source index 0

   // ---------------------------------------------------------------
   // Source indices, table order
   // ---------------------------------------------------------------
   localparam logic [4:0]  IDX_EXT_REQ_ZERO   = 5'h00;
   localparam logic [4:0]  IDX_EXT_REQ_ONE    = 5'h01;
   localparam logic [4:0]  IDX_PIN_CHG_ZERO   = 5'h02;
   localparam logic [4:0]  IDX_PIN_CHG_ONE    = 5'h03;
   localparam logic [4:0]  IDX_PIN_CHG_TWO    = 5'h04;
   localparam logic [4:0]  IDX_WATCHDOG       = 5'h05;
   localparam logic [4:0]  IDX_T2_CMP_A       = 5'h06;
   localparam logic [4:0]  IDX_T2_CMP_B       = 5'h07;
   localparam logic [4:0]  IDX_T2_OVF         = 5'h08;
   localparam logic [4:0]  IDX_T1_CAPTURE     = 5'h09;
   localparam logic [4:0]  IDX_T1_CMP_A       = 5'h0A;
   localparam logic [4:0]  IDX_T1_CMP_B       = 5'h0B;
   localparam logic [4:0]  IDX_T1_OVF         = 5'h0C;
   localparam logic [4:0]  IDX_T0_CMP_A       = 5'h0D;
   localparam logic [4:0]  IDX_T0_CMP_B       = 5'h0E;
   localparam logic [4:0]  IDX_T0_OVF         = 5'h0F;
   localparam logic [4:0]  IDX_SPI_DONE       = 5'h10;
   localparam logic [4:0]  IDX_SER_RX_DONE    = 5'h11;
   localparam logic [4:0]  IDX_SER_TX_EMPTY   = 5'h12;
   localparam logic [4:0]  IDX_SER_TX_DONE    = 5'h13;
   localparam logic [4:0]  IDX_CONV_DONE      = 5'h14;
   localparam logic [4:0]  IDX_NV_READY       = 5'h15;
   localparam logic [4:0]  IDX_ANALOG_CMP     = 5'h16;
   localparam logic [4:0]  IDX_TWO_WIRE       = 5'h17;
   localparam logic [4:0]  IDX_PROG_STORE_RDY = 5'h18;

   // ---------------------------------------------------------------
   // Sequencer states
   // ---------------------------------------------------------------
   typedef enum logic [1:0]
   {
      RIVM_ST_CAPTURE = 2'b00,
      RIVM_ST_ISSUE   = 2'b01,
      RIVM_ST_RUN     = 2'b10
   } rivm_state_t;

endpackage

// ### rivm_req_pick.sv
// Picks the lowest numbered pending interrupt request
`timescale 1ns/10ps
module rivm_req_pick
   import rivm_pkg::*;
(
   // Requests
   input  wire logic [NUM_IRQ-1:0] i_req,
   // Result
   output logic                    o_any,
   output logic [IDX_W-1:0]        o_index
);

   // Scan downward so the lowest set bit is written last and wins
   always_comb
   begin
      o_any   = 1'b0;
      o_index = 5'h00;
      for (int k = NUM_IRQ - 1; k >= 0; k--)
      begin
         if (i_req[k])
         begin
            o_any   = 1'b1;
            o_index = IDX_W'(k);
         end
      end
   end

endmodule

// ### rivm_core_model.sv
// Core fetch unit model: issues vector dispatch pulses after a chosen gap
`timescale 1ns/10ps
module rivm_core_model
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Bench control
   input  wire logic       i_go,
   input  wire logic [1:0] i_gap,
   // Dispatch request to the vector map
   output logic            o_dispatch_req
);
   logic [2:0] cnt_r;

   // ---------------------------------------------------------------
   // Dispatch timing
   // ---------------------------------------------------------------
   // A gap of zero answers two cycles after go; larger gaps mimic a busy pipeline
   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_r          <= 3'h0;
         o_dispatch_req <= 1'b0;
      end
      else
      begin
         o_dispatch_req <= 1'b0;            // One-cycle pulse only
         if (i_go)
            cnt_r <= {1'b0, i_gap} + 3'h1;
         else if (cnt_r != 3'h0)
         begin
            cnt_r <= cnt_r - 3'h1;
            if (cnt_r == 3'h1)
               o_dispatch_req <= 1'b1;
         end
      end
   end
endmodule

// ### tb_top.sv
// Self-checking bench for the reset and interrupt vector map
`timescale 1ns/10ps
module tb_top
   import rivm_pkg::*;
;
   logic        i_clk, i_rst_n, fuse, table_sel, go, dispatch_req;
   logic [12:0] boot_addr, cap_boot;
   logic [3:0]  cause;
   logic [24:0] irq_req;
   logic [1:0]  gap;
   logic        o_fetch_valid, o_is_reset;
   logic [12:0] o_fetch_addr;
   logic [4:0]  o_vec_num;
   int          seed, fails, samples_checked, cycles;

   // ---------------------------------------------------------------
   // Clock, design and core model
   // ---------------------------------------------------------------
   initial
   begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   rivm_vector_map uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_boot_reset_select_fuse(fuse), .i_vector_table_select_bit(table_sel),
      .i_boot_reset_addr(boot_addr), .i_reset_cause(cause),
      .i_irq_req(irq_req), .i_dispatch_req(dispatch_req),
      .o_fetch_valid(o_fetch_valid), .o_fetch_addr(o_fetch_addr),
      .o_vec_num(o_vec_num), .o_is_reset(o_is_reset));

   rivm_core_model core (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_go(go),
      .i_gap(gap), .o_dispatch_req(dispatch_req));

   // ---------------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [12:0] seen,
                        input logic [12:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Table base moves with the select bit; each source takes two words
   function automatic logic [12:0] exp_vec(input int k, input logic sel);
      return (sel ? cap_boot + 13'h0002 : APP_TABLE_BASE) + 13'(2 * k);
   endfunction

   // Bounded wait for the fetch pulse; sampled values are settled ones
   task automatic wait_fetch();
      int n;
      n = 0;
      do
      begin
         @(posedge i_clk);
         n++;
      end
      while (o_fetch_valid !== 1'b1 && n < 20);
      check("fetch_valid", {12'h000, o_fetch_valid}, 13'h0001);
   endtask

   task automatic check_reset_fetch();
      wait_fetch();
      check("reset_addr", o_fetch_addr,
            fuse == FUSE_PROGRAMMED ? cap_boot : APP_RESET_ADDR);
      check("reset_vec", {8'h00, o_vec_num}, 13'h0001);
      check("is_reset", {12'h000, o_is_reset}, 13'h0001);
   endtask

   // Lowest pending bit is k; random bits above it must not win
   task automatic dispatch(input int k, input logic sel);
      @(posedge i_clk);
      irq_req   <= 25'($random(seed)) << k | 25'h1 << k;
      table_sel <= sel;
      gap       <= 2'($random(seed));
      go        <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
      wait_fetch();
      check("vec_addr", o_fetch_addr, exp_vec(k, sel));
      check("vec_num", {8'h00, o_vec_num}, 13'(k + 2));
      check("not_reset", {12'h000, o_is_reset}, 13'h0000);
   endtask

   task automatic cause_reset(input int c, input logic f,
                              input logic [12:0] b);
      @(posedge i_clk);
      cause     <= 4'h1 << c;
      fuse      <= f;
      boot_addr <= b;
      cap_boot  = b;
      @(posedge i_clk);
      cause <= 4'h0;
      check_reset_fetch();
   endtask

   // ---------------------------------------------------------------
   // Timeout
   // ---------------------------------------------------------------
   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles == 4000)
      begin
         fails++;
         complete_run();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      seed = 95;
      fails = 0;
      samples_checked = 0;
      cycles = 0;
      i_rst_n = 1'b0;
      fuse = 1'b1;
      table_sel = 1'b0;
      go = 1'b0;
      gap = 2'h0;
      boot_addr = BOOT_RESET_DFL;
      cap_boot = BOOT_RESET_DFL;
      cause = 4'h0;
      irq_req = 25'h0;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      check_reset_fetch();
      $display("power-up reset test done");
      // Every source with both table placements, 2 Kbyte boot area
      for (int s = 0; s < 2; s++)
         for (int k = 0; k < NUM_IRQ; k++)
            dispatch(k, s[0]);
      $display("vector table test done");
      // Each reset cause with all four fuse and select pairings
      for (int c = 0; c < 4; c++)
      begin
         cause_reset(c, c[0], c == 0 ? BOOT_RESET_DFL
                                     : 13'($random(seed)) & 13'h1F80);
         dispatch($unsigned($random(seed)) % NUM_IRQ, c[1]);
      end
      $display("reset cause test done");
      // Dispatch with nothing pending gets no answer
      @(posedge i_clk);
      irq_req <= 25'h0;
      go      <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
      repeat (8)
      begin
         @(posedge i_clk);
         check("idle_valid", {12'h000, o_fetch_valid}, 13'h0000);
      end
      $display("empty dispatch test done");
      // Asynchronous reset in mid-run with a programmed fuse
      #3;
      i_rst_n   = 1'b0;
      fuse      = FUSE_PROGRAMMED;
      boot_addr = 13'($random(seed)) & 13'h1F80;
      cap_boot  = boot_addr;
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      check_reset_fetch();
      dispatch(NUM_IRQ - 1, 1'b1);
      $display("mid-run reset test done");
      complete_run();
   end
endmodule
